// File: inc/psms_defines.vh
// Constants and timing counts for the mouse link controller
// Operation
// - Two open-drain wires; mouse clocks transfers
// - Controller may hold clock low when idle or during a report
// - Capture data on falling link clock
// - 33-bit shift register, cross domains safely
// - Inhibit: clock low over one period
// - Data low, then release clock
// - Release rising edge samples start bit
// - Host frame is twelve bits
// - Release data after parity bit
// - Enable button sends enable command
// - Clear button resets displayed displacement
// - Four digits show X and Y bytes
// - Three LEDs show mouse buttons
`ifndef PSMS_DEFINES_VH
`define PSMS_DEFINES_VH
// System clock period in ns
`define PSMS_CLK_PERIOD_NS 10
// Inhibit hold time in ns, well over one link period
`define PSMS_INHIBIT_NS 120000
// Inhibit hold in clock cycles
`define PSMS_INHIBIT_CYCLES (`PSMS_INHIBIT_NS / `PSMS_CLK_PERIOD_NS)
// Request hold with data low before clock release, ns
`define PSMS_REQUEST_NS 20000
`define PSMS_REQUEST_CYCLES (`PSMS_REQUEST_NS / `PSMS_CLK_PERIOD_NS)
// Mouse must begin clocking within this time, ms
`define PSMS_START_MS 10
`define PSMS_START_CYCLES (`PSMS_START_MS * 1000000 / `PSMS_CLK_PERIOD_NS)
// Report and command sizes
`define PSMS_REPORT_BITS 33
`define PSMS_SECTION_BITS 11
`define PSMS_TX_BITS 12
// Enable data reporting command byte
`define PSMS_CMD_ENABLE 8'hf4
// Button debounce time in ns
`define PSMS_DEBOUNCE_NS 1000000
`define PSMS_DEBOUNCE_CYCLES (`PSMS_DEBOUNCE_NS / `PSMS_CLK_PERIOD_NS)
// Buffer size
`define PSMS_FIFO_WIDTH 33
`define PSMS_FIFO_DEPTH 8
`endif

// File: rtl/psms_fifo.v
// Parameterised valid/ready FIFO for received mouse reports
`timescale 1ns/1ps
module psms_fifo #(
  parameter WIDTH = 33,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire clock_in,
  input wire rst_n_in,
  // Fill side
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  // Drain side
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage
  reg [AW-1:0] wr_ptr; // Write index
  reg [AW-1:0] rd_ptr; // Read index
  reg [AW:0] count; // Occupancy
  wire push; // Word accepted
  wire pop; // Word removed
  assign in_ready_out = (count != DEPTH[AW:0]);
  assign out_valid_out = (count != {(AW+1){1'b0}});
  assign out_data_out = mem[rd_ptr];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  ////////////////////////////////////////////////////////////////////
  // Storage write, no reset needed
  always @(posedge clock_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
  // Pointers and count
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // psms_fifo

// File: rtl/psms_mouse_ctrl.v
// Mouse link controller: receive reports, send enable, drive displays
`timescale 1ns/1ps
`include "psms_defines.vh"
module psms_mouse_ctrl #(
  parameter INHIBIT_CYCLES = `PSMS_INHIBIT_CYCLES,
  parameter REQUEST_CYCLES = `PSMS_REQUEST_CYCLES,
  parameter START_CYCLES = `PSMS_START_CYCLES,
  parameter DEBOUNCE_CYCLES = `PSMS_DEBOUNCE_CYCLES
) (
  // Clock and reset
  input wire clock_in,
  input wire rst_n_in,
  // Push buttons, active low
  input wire enable_reporting_button_n_in,
  input wire clear_display_button_n_in,
  // Link clock line, open drain
  input wire link_clk_in,
  output wire link_clk_out,
  output wire link_clk_oe_out,
  // Link data line, open drain
  input wire link_data_in,
  output wire link_data_out,
  output wire link_data_oe_out,
  // Displays
  output reg [3:0] x_low_digit_out,
  output reg [3:0] x_high_digit_out,
  output reg [3:0] y_low_digit_out,
  output reg [3:0] y_high_digit_out,
  // Button LEDs
  output reg left_button_led_out,
  output reg right_button_led_out,
  output reg middle_button_led_out,
  // Status
  output reg ack_error_out
);
  // States of the link engine
  localparam ST_IDLE = 3'h0;
  localparam ST_INHIBIT = 3'h1;
  localparam ST_REQUEST = 3'h2;
  localparam ST_SEND = 3'h3;
  localparam ST_ACK = 3'h4;
  localparam ST_RECV = 3'h5;
  // Odd parity over a byte
  function par_odd;
    input [7:0] b;
    begin
      par_odd = ~^b;
    end
  endfunction
  // One 11-bit section is good if start, stop and odd parity hold
  function sec_ok;
    input [10:0] s;
    begin
      sec_ok = (s[0] == 1'b0) && (s[10] == 1'b1) && (s[9] == par_odd(s[8:1]));
    end
  endfunction
  ////////////////////////////////////////////////////////////////////
  // Input synchronisers
  reg clk_s1, clk_s2, clk_s3; // Link clock sync and history
  reg dat_s1, dat_s2; // Link data sync
  reg en_s1, en_s2; // Enable button sync
  reg clr_s1, clr_s2; // Clear button sync
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_s1 <= 1'b1;
      clk_s2 <= 1'b1;
      clk_s3 <= 1'b1;
      dat_s1 <= 1'b1;
      dat_s2 <= 1'b1;
      en_s1 <= 1'b1;
      en_s2 <= 1'b1;
      clr_s1 <= 1'b1;
      clr_s2 <= 1'b1;
    end else begin
      clk_s1 <= link_clk_in;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      dat_s1 <= link_data_in;
      dat_s2 <= dat_s1;
      en_s1 <= enable_reporting_button_n_in;
      en_s2 <= en_s1;
      clr_s1 <= clear_display_button_n_in;
      clr_s2 <= clr_s1;
    end
  end
  wire clk_fall = clk_s3 & ~clk_s2; // Falling link clock edge
  // Only falling edges matter: both directions sample or drive there
  ////////////////////////////////////////////////////////////////////
  // Button debounce: a press is a stable low for the debounce time
  reg [31:0] en_cnt; // Enable stable counter
  reg en_fired; // Press already reported
  reg en_press; // One-cycle press pulse
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en_cnt <= 32'h0;
      en_fired <= 1'b0;
      en_press <= 1'b0;
    end else begin
      en_press <= 1'b0;
      if (en_s2) begin
        en_cnt <= 32'h0;
        en_fired <= 1'b0;
      end else if (en_cnt < DEBOUNCE_CYCLES) begin
        en_cnt <= en_cnt + 32'h1;
      end else if (!en_fired) begin
        en_fired <= 1'b1;
        en_press <= 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Link engine
  reg [2:0] state; // Current state
  reg [31:0] timer; // Phase timer
  reg [32:0] rx_shift;
  reg [5:0] bit_cnt; // Bits moved in frame
  reg [11:0] tx_shift; // Outgoing frame, LSB first
  reg clk_drive; // Pull clock low
  reg dat_drive; // Pull data low
  reg send_pend; // Enable command waiting
  reg rx_valid; // Report ready for FIFO
  wire fifo_ready; // FIFO has room
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
      timer <= 32'h0;
      rx_shift <= 33'h0;
      bit_cnt <= 6'h0;
      tx_shift <= 12'h0;
      clk_drive <= 1'b0;
      dat_drive <= 1'b0;
      send_pend <= 1'b0;
      rx_valid <= 1'b0;
      ack_error_out <= 1'b0;
    end else begin
      if (rx_valid && fifo_ready) begin
        rx_valid <= 1'b0;
      end
      if (en_press) begin
        send_pend <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          clk_drive <= 1'b0;
          dat_drive <= 1'b0;
          bit_cnt <= 6'h0;
          timer <= 32'h0;
          if (send_pend || en_press) begin
            // Abort anything and take the line
            send_pend <= 1'b0;
            clk_drive <= 1'b1;
            state <= ST_INHIBIT;
            tx_shift <= {2'b11, par_odd(`PSMS_CMD_ENABLE), `PSMS_CMD_ENABLE, 1'b0};
          end else if (clk_fall && !rx_valid) begin
            // First falling edge of a report: start bit
            rx_shift <= {dat_s2, rx_shift[32:1]};
            bit_cnt <= 6'h1;
            state <= ST_RECV;
          end
        end
        ST_RECV: begin
          if (send_pend || en_press) begin
            // Host authority: abort report to send
            send_pend <= 1'b0;
            clk_drive <= 1'b1;
            timer <= 32'h0;
            state <= ST_INHIBIT;
            tx_shift <= {2'b11, par_odd(`PSMS_CMD_ENABLE), `PSMS_CMD_ENABLE, 1'b0};
          end else if (clk_fall) begin
            rx_shift <= {dat_s2, rx_shift[32:1]};
            bit_cnt <= bit_cnt + 6'h1;
            timer <= 32'h0;
            if (bit_cnt == `PSMS_REPORT_BITS - 1) begin
              state <= ST_IDLE;
              rx_valid <= sec_ok({dat_s2, rx_shift[32:23]}) && sec_ok(rx_shift[22:12])
                && sec_ok(rx_shift[11:1]);
            end
          end else if (timer >= INHIBIT_CYCLES) begin
            // Stalled frame, drop it
            state <= ST_IDLE;
          end else begin
            timer <= timer + 32'h1;
          end
        end
        ST_INHIBIT: begin
          timer <= timer + 32'h1;
          if (timer >= INHIBIT_CYCLES) begin
            dat_drive <= 1'b1;
            timer <= 32'h0;
            state <= ST_REQUEST;
          end
        end
        ST_REQUEST: begin
          timer <= timer + 32'h1;
          if (timer >= REQUEST_CYCLES) begin
            clk_drive <= 1'b0;
            timer <= 32'h0;
            bit_cnt <= 6'h1;
            tx_shift <= {1'b1, tx_shift[11:1]};
            state <= ST_SEND;
          end
        end
        ST_SEND: begin
          timer <= timer + 32'h1;
          if (clk_fall) begin
            // Put next bit on the line after each falling edge
            timer <= 32'h0;
            bit_cnt <= bit_cnt + 6'h1;
            dat_drive <= ~tx_shift[0];
            tx_shift <= {1'b1, tx_shift[11:1]};
            if (bit_cnt == 6'ha) begin
              dat_drive <= 1'b0;
              state <= ST_ACK;
            end
          end else if (timer >= START_CYCLES) begin
            dat_drive <= 1'b0;
            ack_error_out <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_ACK: begin
          timer <= timer + 32'h1;
          if (clk_fall) begin
            timer <= 32'h0;
            bit_cnt <= bit_cnt + 6'h1;
            if (bit_cnt == `PSMS_TX_BITS - 1) begin
              ack_error_out <= dat_s2;
              state <= ST_IDLE;
            end
          end else if (timer >= START_CYCLES) begin
            ack_error_out <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  // Open-drain drive: only ever pull low
  assign link_clk_out = 1'b0;
  assign link_clk_oe_out = clk_drive;
  assign link_data_out = 1'b0;
  assign link_data_oe_out = dat_drive;
  ////////////////////////////////////////////////////////////////////
  // Report buffer
  wire rep_valid; // Buffered report present
  wire [32:0] rep_data; // Buffered report
  psms_fifo #(
    .WIDTH(`PSMS_FIFO_WIDTH),
    .DEPTH(`PSMS_FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(rx_valid),
    .in_ready_out(fifo_ready),
    .in_data_in(rx_shift),
    .out_valid_out(rep_valid),
    .out_ready_in(clr_s2),
    .out_data_out(rep_data)
  );
  ////////////////////////////////////////////////////////////////////
  // Displacement accumulation and indicators; drained unless clear held
  reg [7:0] x_acc; // Accumulated X
  reg [7:0] y_acc; // Accumulated Y
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      x_acc <= 8'h0;
      y_acc <= 8'h0;
      left_button_led_out <= 1'b0;
      right_button_led_out <= 1'b0;
      middle_button_led_out <= 1'b0;
      x_low_digit_out <= 4'h0;
      x_high_digit_out <= 4'h0;
      y_low_digit_out <= 4'h0;
      y_high_digit_out <= 4'h0;
    end else begin
      if (!clr_s2) begin
        x_acc <= 8'h0;
        y_acc <= 8'h0;
      end else if (rep_valid) begin
        x_acc <= x_acc + rep_data[19:12];
        y_acc <= y_acc + rep_data[30:23];
        left_button_led_out <= rep_data[1];
        right_button_led_out <= rep_data[2];
        middle_button_led_out <= rep_data[3];
      end
      x_low_digit_out <= x_acc[3:0];
      x_high_digit_out <= x_acc[7:4];
      y_low_digit_out <= y_acc[3:0];
      y_high_digit_out <= y_acc[7:4];
    end
  end
endmodule // psms_mouse_ctrl

// File: test/psms_mouse_ctrl_asserts.sv
// Port checker for the mouse link controller
`timescale 1ns/1ps
module psms_mouse_ctrl_asserts #(
  parameter INHIBIT_CYCLES = 50
) (
  // Clock, reset, buttons
  input wire clock_in,
  input wire rst_n_in,
  input wire enable_reporting_button_n_in,
  input wire clear_display_button_n_in,
  // Link lines
  input wire link_clk_in,
  input wire link_clk_out,
  input wire link_clk_oe_out,
  input wire link_data_out,
  input wire link_data_oe_out,
  // Displays
  input wire [3:0] x_low_digit_out,
  input wire [3:0] x_high_digit_out,
  input wire [3:0] y_low_digit_out,
  input wire [3:0] y_high_digit_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // Cycles the clock line has been pulled
  integer hold;
  // Cycles since the enable button was low
  integer since_btn;
  ////////////////////////////////////////
  // Helper counters
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold <= 0;
      since_btn <= 1000;
    end else begin
      hold <= link_clk_oe_out ? hold + 1 : 0;
      if (!enable_reporting_button_n_in)
        since_btn <= 0;
      else if (since_btn < 1000)
        since_btn <= since_btn + 1;
    end
  end
  ////////////////////////////////////////
  // Steps of a send request
  sequence s_inhibit;
    $rose(link_clk_oe_out);
  endsequence
  sequence s_release;
    $fell(link_clk_oe_out);
  endsequence
  chk_clk_pull_only: assert property (link_clk_out == 1'b0) else $error("clk driven high");
  chk_data_pull_only: assert property (link_data_out == 1'b0) else $error("data high");
  chk_inhibit_long: assert property (s_release |-> hold > INHIBIT_CYCLES) else $error("short");
  chk_inhibit_clean: assert property (s_inhibit |-> !link_data_oe_out) else $error("early");
  chk_start_before_rel: assert property (s_release |-> $past(link_data_oe_out)) else $error("no start");
  chk_enable_cause: assert property (s_inhibit |-> since_btn < 40) else $error("no press");
  chk_bit_after_fall: assert property (($changed(link_data_oe_out) && !link_clk_oe_out
    && !$past(link_clk_oe_out)) |-> !$past(link_clk_in, 2)) else $error("bit off fall");
  chk_clear_zero: assert property (!clear_display_button_n_in [*5] |-> {y_high_digit_out,
    y_low_digit_out, x_high_digit_out, x_low_digit_out} == 16'h0000) else $error("nz");
endmodule // psms_mouse_ctrl_asserts

// File: test/psms_mouse_model.sv
// Behavioural mouse on the far side of the link
`timescale 1ns/1ps
module psms_mouse_model (
  // Wire levels
  input wire clk_line_in,
  input wire data_line_in,
  // Pulls, high pulls the wire low
  output reg clk_pull_out,
  output reg data_pull_out
);
  reg busy = 1'b0; // Own transfer running
  reg enabled = 1'b0; // Reporting on
  reg no_ack = 1'b0; // Withhold acknowledge
  reg [9:0] rx; // Data, parity, stop
  integer n_cmd = 0;
  integer i;
  initial begin
    clk_pull_out = 1'b0;
    data_pull_out = 1'b0;
  end
  // One 125 ns link period; only the mouse clocks
  task pulse;
    begin
      #62.5 clk_pull_out = 1'b1;
      #62.5 clk_pull_out = 1'b0;
    end
  endtask
  // One section; bad flips parity
  task section(input [7:0] b, input bad);
    integer k;
    begin
      data_pull_out = 1'b1;
      pulse;
      for (k = 0; k < 8; k = k + 1) begin
        data_pull_out = !b[k];
        pulse;
      end
      data_pull_out = (^b) ^ bad;
      pulse;
      data_pull_out = 1'b0;
      pulse;
    end
  endtask
  // Report of three sections, silent until enabled
  task send_report(input [7:0] b0, input [7:0] b1, input [7:0] b2, input bad);
    begin
      // Step off the system clock edge before touching the wires
      #1;
      if (enabled) begin
        busy = 1'b1;
        section(b0, bad);
        section(b1, bad);
        section(b2, bad);
        busy = 1'b0;
      end
    end
  endtask
  ////////////////////////////////////////
  // Request seen at clock release with data low
  always @(posedge clk_line_in) if (!busy && !data_line_in) begin
    busy = 1'b1;
    #2000;
    for (i = 0; i < 10; i = i + 1) begin
      pulse;
      #1 rx[i] = data_line_in;
    end
    data_pull_out = !no_ack;
    pulse;
    data_pull_out = 1'b0;
    n_cmd = n_cmd + 1;
    if (rx == 10'h2f4) enabled = 1'b1;
    busy = 1'b0;
  end
endmodule // psms_mouse_model

// File: test/tb.sv
// Self-checking bench for the mouse link controller
`timescale 1ns/1ps
module tb;
  reg clock_in = 1'b0;
  reg rst_n_in = 1'b0;
  reg en_n = 1'b1;
  reg clr_n = 1'b1;
  wire lc, ld, lco, lcoe, ldo, ldoe, lb, rb, mb, ae, mcp, mdp;
  wire [3:0] xl, xh, yl, yh;
  integer fail_count = 0;
  integer n_compared = 0;
  integer cyc = 0;
  integer k;
  // Pulled-up wires
  assign lc = !(lcoe || mcp);
  assign ld = !(ldoe || mdp);
  psms_mouse_ctrl #(.INHIBIT_CYCLES(50), .REQUEST_CYCLES(10),
    .START_CYCLES(2000), .DEBOUNCE_CYCLES(5)) dut (
    .clock_in(clock_in), .rst_n_in(rst_n_in),
    .enable_reporting_button_n_in(en_n), .clear_display_button_n_in(clr_n),
    .link_clk_in(lc), .link_clk_out(lco), .link_clk_oe_out(lcoe),
    .link_data_in(ld), .link_data_out(ldo), .link_data_oe_out(ldoe),
    .x_low_digit_out(xl), .x_high_digit_out(xh),
    .y_low_digit_out(yl), .y_high_digit_out(yh),
    .left_button_led_out(lb), .right_button_led_out(rb),
    .middle_button_led_out(mb), .ack_error_out(ae));
  psms_mouse_model mouse (.clk_line_in(lc), .data_line_in(ld),
    .clk_pull_out(mcp), .data_pull_out(mdp));
  always #5 clock_in = ~clock_in;
  task check(input [15:0] seen, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("compared %0d mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // Hang guard
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      wrap_up;
    end
  end
  task wait_cyc(input integer n);
    repeat (n) @(posedge clock_in);
  endtask
  // Press enable, wait for the mouse to take a command
  task do_enable;
    integer old;
    begin
      old = mouse.n_cmd;
      en_n <= 1'b0;
      wait_cyc(40);
      en_n <= 1'b1;
      for (k = 0; k < 5000 && mouse.n_cmd == old; k = k + 1) wait_cyc(1);
      wait_cyc(30);
    end
  endtask
  ////////////////////////////////////////
  task t_reset;
    begin
      check({yh, yl, xh, xl}, 16'h0000);
      check({8'h00, lcoe, ldoe, lb, rb, mb, ae, lco, ldo}, 16'h0000);
      $display("test reset done");
    end
  endtask
  task t_enable;
    begin
      do_enable;
      check({6'h00, mouse.rx}, 16'h02f4);
      check({15'h0000, ae}, 16'h0000);
      $display("test enable done");
    end
  endtask
  task t_report;
    begin
      mouse.send_report(8'h05, 8'h12, 8'h34, 1'b0);
      wait_cyc(30);
      check({yh, yl, xh, xl}, 16'h3412);
      check({13'h0000, mb, rb, lb}, 16'h0005);
      mouse.send_report(8'h01, 8'h10, 8'h10, 1'b1);
      wait_cyc(30);
      check({yh, yl, xh, xl}, 16'h3412);
      mouse.send_report(8'h02, 8'h01, 8'hff, 1'b0);
      wait_cyc(30);
      check({yh, yl, xh, xl}, 16'h3313);
      check({13'h0000, mb, rb, lb}, 16'h0002);
      $display("test report done");
    end
  endtask
  // Clear held stalls the buffer; eight reports fill it
  task t_clear_fifo;
    begin
      clr_n <= 1'b0;
      wait_cyc(10);
      check({yh, yl, xh, xl}, 16'h0000);
      for (k = 0; k < 8; k = k + 1) mouse.send_report(8'h00, 8'h01, 8'h02, 1'b0);
      check({yh, yl, xh, xl}, 16'h0000);
      wait_cyc(1);
      clr_n <= 1'b1;
      wait_cyc(40);
      check({yh, yl, xh, xl}, 16'h1008);
      check({13'h0000, mb, rb, lb}, 16'h0000);
      $display("test clear and buffer done");
    end
  endtask
  task t_no_ack;
    begin
      mouse.no_ack = 1'b1;
      do_enable;
      check({15'h0000, ae}, 16'h0001);
      mouse.no_ack = 1'b0;
      do_enable;
      check({15'h0000, ae}, 16'h0000);
      $display("test acknowledge done");
    end
  endtask
  initial begin
    wait_cyc(10);
    rst_n_in <= 1'b1;
    wait_cyc(5);
    t_reset;
    t_enable;
    t_report;
    t_clear_fifo;
    t_no_ack;
    wrap_up;
  end
endmodule // tb
bind psms_mouse_ctrl psms_mouse_ctrl_asserts #(.INHIBIT_CYCLES(INHIBIT_CYCLES)) u_chk (
  .clock_in(clock_in), .rst_n_in(rst_n_in),
  .enable_reporting_button_n_in(enable_reporting_button_n_in),
  .clear_display_button_n_in(clear_display_button_n_in),
  .link_clk_in(link_clk_in), .link_clk_out(link_clk_out),
  .link_clk_oe_out(link_clk_oe_out), .link_data_out(link_data_out),
  .link_data_oe_out(link_data_oe_out),
  .x_low_digit_out(x_low_digit_out), .x_high_digit_out(x_high_digit_out),
  .y_low_digit_out(y_low_digit_out), .y_high_digit_out(y_high_digit_out));
